/* File: ffc_fault_flag_regs.sv */
// fault event flags, their clear registers and an avalon-mm slave
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// How it works
// RULE1: external supply fault bits 7..5, read only
// RULE2: fault bit reads one while event recorded
// RULE3: misc clear bit7 overtemp, bit6 power-disable
// RULE4: overvoltage clear bits 7..1, bit0 reserved
// RULE5: undervoltage clear bits 7..1, bit0 reserved
// RULE6: misc flags: overtemp bit7, power-disable bit6
// RULE7: overvoltage flags latched in bits 7..1
// RULE8: undervoltage flags latched in bits 7..1
// RULE9: one clears, zero keeps, fault may reset
module ffc_fault_flag_regs
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [ffc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [ffc_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [ffc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic overtemp_fault,
	input wire logic power_disable_input,
	input wire logic [6:0] ov_fault,
	input wire logic [6:0] uv_fault,
	input wire logic [2:0] ext_pg_fail,
	output logic irq
);
	import ffc_pkg::*;

	//////////////////////////////////////////////////////////////////
	// helpers

	// true when the byte address selects register index idx
	function automatic logic reg_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [IDX_W-1:0] idx
	);
		reg_hit = (addr[ADDR_W-1:2] == idx);
	endfunction

	// next flag value: hardware set wins over software clear
	function automatic logic [REG_W-1:0] flag_next(
		input logic [REG_W-1:0] cur,
		input logic [REG_W-1:0] clr,
		input logic [REG_W-1:0] set
	);
		flag_next = (cur & ~clr) | set;
	endfunction

	//////////////////////////////////////////////////////////////////
	// bus handshake

	// high in the second cycle of a request, the answer cycle
	logic ack_ff;
	// a request is on the bus
	logic bus_req;
	// write committed at this edge
	logic wr_go;
	// read data captured at this edge
	logic rd_take;

	assign bus_req = avs_read | avs_write;
	// one wait cycle, then the answer
	assign avs_waitrequest = bus_req & ~ack_ff;
	assign wr_go = avs_write & ack_ff & avs_byteenable[0];
	assign rd_take = avs_read & ~ack_ff;

	// answer strobe, drops after each accepted request
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ack_ff <= 1'b0;
		else
			ack_ff <= bus_req & ~ack_ff;
	end

	//////////////////////////////////////////////////////////////////
	// event inputs aligned to register bit positions

	// misc set vector
	logic [REG_W-1:0] misc_set;
	// overvoltage set vector
	logic [REG_W-1:0] ov_set;
	// undervoltage set vector
	logic [REG_W-1:0] uv_set;
	// external supply set vector
	logic [REG_W-1:0] ext_set;

	assign misc_set = {overtemp_fault, power_disable_input, 6'h00}; // [RULE6]
	assign ov_set = {ov_fault, 1'b0}; // [RULE7]
	assign uv_set = {uv_fault, 1'b0}; // [RULE8]
	assign ext_set = {ext_pg_fail, 5'h00}; // [RULE1]

	//////////////////////////////////////////////////////////////////
	// clear registers

	// stored clear register contents, readable back
	logic [REG_W-1:0] misc_clr_ff;
	logic [REG_W-1:0] ov_clr_ff;
	logic [REG_W-1:0] uv_clr_ff;
	// one-cycle clear pulses aimed at the flags
	logic [REG_W-1:0] misc_clr;
	logic [REG_W-1:0] ov_clr;
	logic [REG_W-1:0] uv_clr;
	// byte written this cycle
	logic [REG_W-1:0] wr_byte;

	assign wr_byte = avs_writedata[REG_W-1:0];

	// a written one clears, a zero leaves the flag alone
	always_comb
	begin
		misc_clr = '0;
		ov_clr = '0;
		uv_clr = '0;
		if (wr_go && reg_hit(avs_address, IDX_MISC_CLR))
			misc_clr = wr_byte & MISC_VALID; // [RULE3] [RULE9]
		else if (wr_go && reg_hit(avs_address, IDX_OV_CLR))
			ov_clr = wr_byte & RAIL_VALID; // [RULE4] [RULE9]
		else if (wr_go && reg_hit(avs_address, IDX_UV_CLR))
			uv_clr = wr_byte & RAIL_VALID; // [RULE5] [RULE9]
	end

	// clear registers keep the last written byte
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			misc_clr_ff <= RST_CLR;
			ov_clr_ff <= RST_CLR;
			uv_clr_ff <= RST_CLR;
		end
		else if (wr_go && reg_hit(avs_address, IDX_MISC_CLR))
			misc_clr_ff <= wr_byte;
		else if (wr_go && reg_hit(avs_address, IDX_OV_CLR))
			ov_clr_ff <= wr_byte;
		else if (wr_go && reg_hit(avs_address, IDX_UV_CLR))
			uv_clr_ff <= wr_byte;
	end

	//////////////////////////////////////////////////////////////////
	// latched flags

	logic [REG_W-1:0] misc_flags_ff;
	logic [REG_W-1:0] ov_flags_ff;
	logic [REG_W-1:0] uv_flags_ff;
	logic [REG_W-1:0] ext_flags_ff;
	logic [REG_W-1:0] nxt_misc_flags;
	logic [REG_W-1:0] nxt_ov_flags;
	logic [REG_W-1:0] nxt_uv_flags;
	logic [REG_W-1:0] nxt_ext_flags;

	// a fault still present sets its flag again right away
	assign nxt_misc_flags = flag_next(misc_flags_ff, misc_clr, misc_set); // [RULE6] [RULE9]
	assign nxt_ov_flags = flag_next(ov_flags_ff, ov_clr, ov_set); // [RULE7] [RULE9]
	assign nxt_uv_flags = flag_next(uv_flags_ff, uv_clr, uv_set); // [RULE8] [RULE9]
	// external flags have no clear path here; writes never reach them
	assign nxt_ext_flags = ext_flags_ff | ext_set; // [RULE1] [RULE2]

	// flag storage
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			misc_flags_ff <= RST_FLAGS;
			ov_flags_ff <= RST_FLAGS;
			uv_flags_ff <= RST_FLAGS;
			ext_flags_ff <= RST_FLAGS;
		end
		else
		begin
			misc_flags_ff <= nxt_misc_flags;
			ov_flags_ff <= nxt_ov_flags;
			uv_flags_ff <= nxt_uv_flags;
			ext_flags_ff <= nxt_ext_flags;
		end
	end

	//////////////////////////////////////////////////////////////////
	// interrupt status and mask

	// sticky status, one bit per flag group
	logic [IRQ_W-1:0] irq_status_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	// a flag went from clear to set
	logic [IRQ_W-1:0] irq_event;
	// write-one-to-clear pulse
	logic [IRQ_W-1:0] irq_clr;

	assign irq_event[IRQ_MISC_BIT] = |(misc_set & ~misc_flags_ff);
	assign irq_event[IRQ_OV_BIT] = |(ov_set & ~ov_flags_ff);
	assign irq_event[IRQ_UV_BIT] = |(uv_set & ~uv_flags_ff);
	assign irq_event[IRQ_EXT_BIT] = |(ext_set & ~ext_flags_ff);
	assign irq_clr = (wr_go && reg_hit(avs_address, IDX_IRQ_STATUS)) ?
		avs_writedata[IRQ_W-1:0] : '0;

	// new event wins over a clear in the same cycle
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			irq_status_ff <= RST_IRQ;
		else
			irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_event;
	end

	// mask register, one enables the group
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			irq_mask_ff <= RST_IRQ;
		else if (wr_go && reg_hit(avs_address, IDX_IRQ_MASK))
			irq_mask_ff <= avs_writedata[IRQ_W-1:0];
	end

	// level interrupt output
	assign irq = |(irq_status_ff & irq_mask_ff);

	//////////////////////////////////////////////////////////////////
	// read path

	// value selected by the current address
	logic [DATA_W-1:0] rd_mux;

	// decode; unmapped addresses read zero
	always_comb
	begin
		rd_mux = RD_ZERO;
		if (reg_hit(avs_address, IDX_MISC_FLAGS))
			rd_mux[REG_W-1:0] = misc_flags_ff; // [RULE6]
		else if (reg_hit(avs_address, IDX_OV_FLAGS))
			rd_mux[REG_W-1:0] = ov_flags_ff; // [RULE7]
		else if (reg_hit(avs_address, IDX_UV_FLAGS))
			rd_mux[REG_W-1:0] = uv_flags_ff; // [RULE8]
		else if (reg_hit(avs_address, IDX_EXT_FLAGS))
			rd_mux[REG_W-1:0] = ext_flags_ff; // [RULE2]
		else if (reg_hit(avs_address, IDX_MISC_CLR))
			rd_mux[REG_W-1:0] = misc_clr_ff;
		else if (reg_hit(avs_address, IDX_OV_CLR))
			rd_mux[REG_W-1:0] = ov_clr_ff;
		else if (reg_hit(avs_address, IDX_UV_CLR))
			rd_mux[REG_W-1:0] = uv_clr_ff;
		else if (reg_hit(avs_address, IDX_IRQ_STATUS))
			rd_mux[IRQ_W-1:0] = irq_status_ff;
		else if (reg_hit(avs_address, IDX_IRQ_MASK))
			rd_mux[IRQ_W-1:0] = irq_mask_ff;
	end

	// read data captured in the wait cycle, stands in the answer cycle
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			avs_readdata <= RD_ZERO;
		else if (rd_take)
			avs_readdata <= rd_mux;
	end

	//////////////////////////////////////////////////////////////////
	// checks

	default clocking chk_clk @(posedge clk); endclocking
	default disable iff (reset);

	// external fault bits are untouched by bus writes
	chk_ext_read_only: assert property ( // [RULE1]
		wr_go && reg_hit(avs_address, IDX_EXT_FLAGS)
		|=> ext_flags_ff == ($past(ext_flags_ff) | $past(ext_set)))
		else $error("external fault flags changed by a write");

	// a power-good failure is recorded and held
	chk_ext_event_held: assert property ( // [RULE2]
		ext_pg_fail[0] |=> ext_flags_ff[EXT_LO_BIT] [*3])
		else $error("external fault flag not held after event");

	// overtemp clear drops bit seven when the fault is gone
	chk_misc_clear_ot: assert property ( // [RULE3]
		misc_clr[MISC_OT_BIT] && !overtemp_fault
		|=> !misc_flags_ff[MISC_OT_BIT])
		else $error("overtemp flag not cleared");

	// overvoltage clear bit one clears the linear output flag
	chk_ov_clear_bit: assert property ( // [RULE4]
		wr_go && reg_hit(avs_address, IDX_OV_CLR)
		&& avs_writedata[RAIL_LO_BIT] && !ov_fault[0]
		|=> !ov_flags_ff[RAIL_LO_BIT])
		else $error("overvoltage flag not cleared");

	// undervoltage clear bit seven clears the input flag
	chk_uv_clear_bit: assert property ( // [RULE5]
		wr_go && reg_hit(avs_address, IDX_UV_CLR)
		&& avs_writedata[RAIL_HI_BIT] && !uv_fault[6]
		|=> !uv_flags_ff[RAIL_HI_BIT])
		else $error("undervoltage flag not cleared");

	// power-disable sets bit six, reserved misc bits stay zero
	chk_misc_pd_flag: assert property ( // [RULE6]
		power_disable_input
		|=> misc_flags_ff[MISC_PD_BIT] && misc_flags_ff[5:0] == 6'h00)
		else $error("power-disable flag wrong");

	// an overvoltage flag persists until cleared
	chk_ov_latched: assert property ( // [RULE7]
		ov_flags_ff[RAIL_HI_BIT] && !ov_clr[RAIL_HI_BIT]
		|=> ov_flags_ff[RAIL_HI_BIT] && !ov_flags_ff[0])
		else $error("overvoltage flag lost");

	// undervoltage flags read back on the bus at the answer
	chk_uv_readback: assert property ( // [RULE8]
		rd_take && reg_hit(avs_address, IDX_UV_FLAGS)
		|=> !avs_waitrequest && avs_readdata == {24'h00_0000, $past(uv_flags_ff)})
		else $error("undervoltage readback mismatch");

	// a fault present during its clear sets the flag again
	chk_set_wins: assert property ( // [RULE9]
		ov_clr[RAIL_HI_BIT] && ov_fault[6]
		|=> ov_flags_ff[RAIL_HI_BIT])
		else $error("clear overrode a present fault");

	// writing zero leaves an undervoltage flag set
	chk_zero_keeps: assert property ( // [RULE9]
		wr_go && reg_hit(avs_address, IDX_UV_CLR)
		&& !avs_writedata[RAIL_LO_BIT] && uv_flags_ff[RAIL_LO_BIT]
		|=> uv_flags_ff[RAIL_LO_BIT])
		else $error("zero write cleared a flag");

	// every request is answered after exactly one wait cycle
	chk_bus_answer: assert property (
		bus_req && !ack_ff |-> avs_waitrequest ##1 (!bus_req || !avs_waitrequest))
		else $error("bus answer timing wrong");

	// interrupt follows unmasked status
	chk_irq_level: assert property (
		$rose(irq_status_ff[IRQ_OV_BIT]) && irq_mask_ff[IRQ_OV_BIT] |-> irq)
		else $error("interrupt not raised");
endmodule
`default_nettype wire

/* File: ffc_pkg.sv */
// constants shared by the fault flag and clear register bank
`default_nettype none
package ffc_pkg;
	// bus widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 8;
	localparam int unsigned IDX_W = 6;
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_MISC_FLAGS = 6'h08;
	localparam logic [5:0] IDX_OV_FLAGS = 6'h09;
	localparam logic [5:0] IDX_UV_FLAGS = 6'h0A;
	localparam logic [5:0] IDX_EXT_FLAGS = 6'h0C;
	localparam logic [5:0] IDX_MISC_CLR = 6'h0D;
	localparam logic [5:0] IDX_OV_CLR = 6'h0E;
	localparam logic [5:0] IDX_UV_CLR = 6'h0F;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h18;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h19;
	// field positions
	localparam int unsigned MISC_OT_BIT = 7;
	localparam int unsigned MISC_PD_BIT = 6;
	localparam int unsigned RAIL_HI_BIT = 7;
	localparam int unsigned RAIL_LO_BIT = 1;
	localparam int unsigned EXT_HI_BIT = 7;
	localparam int unsigned EXT_LO_BIT = 5;
	// implemented bits of each flag register
	localparam logic [7:0] MISC_VALID = 8'hC0;
	localparam logic [7:0] RAIL_VALID = 8'hFE;
	localparam logic [7:0] EXT_VALID = 8'hE0;
	// interrupt status bits, one per flag group
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_MISC_BIT = 0;
	localparam int unsigned IRQ_OV_BIT = 1;
	localparam int unsigned IRQ_UV_BIT = 2;
	localparam int unsigned IRQ_EXT_BIT = 3;
	// reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_CLR = 8'h00;
	localparam logic [3:0] RST_IRQ = 4'h0;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: ffc_fault_flag_regs_bench.sv */
// self-checking bench for the fault flag and clear register bank
`timescale 1ns/100ps
`default_nettype none
module ffc_fault_flag_regs_bench;
	import ffc_pkg::*;
	logic clk = 1'b0; // 250 mhz system clock
	logic reset = 1'b1; // async, active high
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic overtemp_fault = 1'b0;
	logic power_disable_input = 1'b0;
	logic [6:0] ov_fault = 7'h00;
	logic [6:0] uv_fault = 7'h00;
	logic [2:0] ext_pg_fail = 3'h0;
	logic irq;
	int error_cnt = 0; // mismatches seen
	int num_checks = 0; // comparisons made
	logic [7:0] exp_v; // running expectation
	logic [7:0] fl_a; // flag register address of a group
	logic [7:0] cl_a; // clear register address of a group
	logic [7:0] map_a [10] = '{8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h60, 8'h64, 8'h40};
	//////////////////////////////////////////////////////////////////////
	// design under test
	ffc_fault_flag_regs i_ffc_fault_flag_regs (.clk(clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.overtemp_fault(overtemp_fault), .power_disable_input(power_disable_input),
		.ov_fault(ov_fault), .uv_fault(uv_fault), .ext_pg_fail(ext_pg_fail), .irq(irq));
	// clock toggles every half period
	always #2 clk = ~clk;
	//////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic stop_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one comparison of a value
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// waits for waitrequest low at a rising edge, bounded
	task automatic wait_answer();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0)
		begin
			check("waitrequest", 32'h0000_0000, {31'h0, avs_waitrequest});
			stop_test();
		end
	endtask
	// bus write, request held until answered
	task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= be;
		avs_write <= 1'b1;
		wait_answer();
		avs_write <= 1'b0;
	endtask
	// bus read compared against an expected byte
	task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		wait_answer();
		check($sformatf("register %h", a), {24'h00_0000, exp}, avs_readdata);
		avs_read <= 1'b0;
	endtask
	// one-cycle fault conditions
	task automatic pulse(input logic ot, input logic pd, input logic [6:0] ov,
		input logic [6:0] uv, input logic [2:0] ext);
		@(posedge clk);
		{overtemp_fault, power_disable_input, ov_fault, uv_fault, ext_pg_fail} <= {ot, pd, ov, uv, ext};
		@(posedge clk);
		{overtemp_fault, power_disable_input, ov_fault, uv_fault, ext_pg_fail} <= 19'h0_0000;
	endtask
	// irq level once the last write has landed
	task automatic irq_is(input logic exp);
		@(posedge clk);
		check("irq", {31'h0, exp}, {31'h0, irq});
	endtask
	//////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		// every register, and an unmapped word, reads zero after reset
		foreach (map_a[i])
			expect_reg(map_a[i], 8'h00);
		// external supply faults latch one by one and ignore writes
		exp_v = 8'h00;
		for (int k = 0; k < 3; k++)
		begin
			pulse(1'b0, 1'b0, 7'h00, 7'h00, 3'h4 >> k);
			exp_v = exp_v | (8'h80 >> k);
			expect_reg(8'h30, exp_v);
		end
		bus_write(8'h30, 8'h00, 4'hf);
		expect_reg(8'h30, 8'he0);
		// shutdown flags, read only, cleared one at a time
		pulse(1'b1, 1'b0, 7'h00, 7'h00, 3'h0);
		expect_reg(8'h20, 8'h80);
		pulse(1'b0, 1'b1, 7'h00, 7'h00, 3'h0);
		bus_write(8'h20, 8'h00, 4'hf);
		expect_reg(8'h20, 8'hc0);
		bus_write(8'h34, 8'h80, 4'hf);
		expect_reg(8'h20, 8'h40);
		expect_reg(8'h34, 8'h80);
		bus_write(8'h34, 8'h7f, 4'hf);
		expect_reg(8'h20, 8'h00);
		// rail groups: set all, a zero keeps, then each clear bit alone
		for (int g = 0; g < 2; g++)
		begin
			fl_a = g ? 8'h28 : 8'h24;
			cl_a = g ? 8'h3c : 8'h38;
			pulse(1'b0, 1'b0, g ? 7'h00 : 7'h7f, g ? 7'h7f : 7'h00, 3'h0);
			bus_write(cl_a, 8'h01, 4'hf);
			exp_v = 8'hfe;
			expect_reg(fl_a, exp_v);
			bus_write(cl_a, 8'hfe, 4'h0);
			expect_reg(fl_a, exp_v);
			for (int k = 0; k < 7; k++)
			begin
				bus_write(cl_a, 8'h80 >> k, 4'hf);
				exp_v = exp_v & ~(8'h80 >> k);
				expect_reg(fl_a, exp_v);
				expect_reg(cl_a, 8'h80 >> k);
			end
		end
		// a condition seen only at the clearing edge still wins over its clear
		fork
			bus_write(8'h38, 8'h80, 4'hf);
			begin
				// the answer edge is the second edge after the request rises
				repeat (2) @(posedge clk);
				ov_fault <= 7'h40;
				@(posedge clk);
				ov_fault <= 7'h00;
			end
		join
		expect_reg(8'h24, 8'h80);
		@(posedge clk);
		ov_fault <= 7'h00;
		bus_write(8'h38, 8'h80, 4'hf);
		expect_reg(8'h24, 8'h00);
		// group events, mask and write-one-to-clear status
		expect_reg(8'h60, 8'h0f);
		irq_is(1'b0);
		bus_write(8'h64, 8'h02, 4'hf);
		irq_is(1'b1);
		bus_write(8'h60, 8'h02, 4'hf);
		irq_is(1'b0);
		expect_reg(8'h60, 8'h0d);
		bus_write(8'h60, 8'h0d, 4'hf);
		expect_reg(8'h60, 8'h00);
		// a new overvoltage event while its group is unmasked raises irq
		pulse(1'b0, 1'b0, 7'h01, 7'h00, 3'h0);
		irq_is(1'b1);
		expect_reg(8'h24, 8'h02);
		bus_write(8'h60, 8'h02, 4'hf);
		pulse(1'b0, 1'b0, 7'h00, 7'h01, 3'h0);
		irq_is(1'b0);
		bus_write(8'h64, 8'h04, 4'hf);
		irq_is(1'b1);
		expect_reg(8'h28, 8'h02);
		stop_test();
	end
endmodule
`default_nettype wire
